// file: src/coherent_cache_transaction_agent.sv
`timescale 1ns/100ps
`default_nettype none
module coherent_cache_transaction_agent (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   req_valid,
  input  wire agent_pkg::req_t        req,
  output logic                        req_ready,
  output logic                        op_done,
  output logic                        txn_valid,
  output agent_pkg::txn_t             txn,
  input  wire logic                   txn_ready,
  input  wire logic                   rd_done,
  input  wire logic                   wr_done,
  input  wire logic                   snp_valid,
  input  wire agent_pkg::snp_t        snp,
  output logic                        snp_rsp_valid,
  output agent_pkg::snp_rsp_t         snp_rsp,
  output logic                        snp_data_valid,
  output logic [agent_pkg::IDX_W-1:0] snp_data_idx
);
  import agent_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } fsm_t;

  fsm_t        fsm_q,       fsm_d;
  txn_t        txn_q,       txn_d;
  logic        txn_valid_q, txn_valid_d;
  txn_t        pend_q,      pend_d;
  logic        pend_vld_q,  pend_vld_d;
  logic        got_rd_q,    got_rd_d;
  logic        got_wr_q,    got_wr_d;
  logic        done_q,      done_d;
  logic        ready_q,     ready_d;

  line_state_t state_q [LINES];
  line_state_t state_d [LINES];

  logic             table_we;
  logic [IDX_W-1:0] table_idx;
  line_state_t      table_val;
  logic             take;
  line_state_t      cur;
  txn_kind_t        first_k;
  txn_kind_t        second_k;
  logic             rd_ok;
  logic             wr_ok;
  logic             cacheable;

  line_state_t      snp_cur;
  line_state_t      snp_next;
  snp_rsp_t         snp_dec;

  snp_rsp_t         rsp_q,      rsp_d;
  logic             rsp_vld_q,  rsp_vld_d;
  logic             dvld_q,     dvld_d;
  logic [IDX_W-1:0] didx_q,     didx_d;

  // Transaction choice and sequencing
  always_comb begin
    fsm_d       = fsm_q;
    txn_d       = txn_q;
    txn_valid_d = txn_valid_q;
    pend_d      = pend_q;
    pend_vld_d  = pend_vld_q;
    got_rd_d    = got_rd_q;
    got_wr_d    = got_wr_q;
    done_d      = 1'b0;
    table_we    = 1'b0;
    table_idx   = req.idx;
    table_val   = LINE_INVALID;
    first_k     = TX_NONE;
    second_k    = TX_NONE;
    cur         = state_q[req.idx];
    cacheable   = (req.dom != DOM_SYSTEM);
    take        = req_valid && ready_q && !snp_valid;
    rd_ok       = got_rd_q || rd_done || !txn_q.on_rd;
    wr_ok       = got_wr_q || wr_done || !txn_q.on_wr;
    unique case (fsm_q)
      ST_IDLE: begin
        if (take) begin
          unique case (req.op)
            OP_READ_ONCE: begin
              first_k = TX_READ_ONCE;
            end
            OP_STORE: begin
              // Unique write goes to memory, local copy dropped
              second_k = req.full_line ? TX_WRITE_LINE_UNIQUE
                                       : TX_WRITE_UNIQUE;
              if (cur == LINE_DIRTY && !req.full_line) begin
                first_k = TX_WRITE_BACK;
              end else begin
                first_k  = second_k;
                second_k = TX_NONE;
              end
              table_we  = 1'b1;
              table_val = LINE_INVALID;
            end
            OP_FILL: begin
              table_we  = cacheable;
              table_val = LINE_CLEAN;
            end
            OP_WRITE_LOCAL: begin
              table_we  = cacheable && (cur != LINE_INVALID);
              table_val = LINE_DIRTY;
            end
            OP_EVICT: begin
              if (cur == LINE_DIRTY) begin
                first_k = TX_WRITE_BACK;
              end else if (cur == LINE_CLEAN && req.to_lower) begin
                first_k = TX_WRITE_EVICT;
              end else if (cur == LINE_CLEAN) begin
                first_k = TX_EVICT;
              end
              table_we  = 1'b1;
              table_val = LINE_INVALID;
            end
            OP_CLEAN: begin
              if (cur == LINE_DIRTY) begin
                first_k   = TX_WRITE_CLEAN;
                table_we  = 1'b1;
                table_val = LINE_CLEAN;
              end
            end
            OP_CMO: begin
              unique case (req.cmo)
                CMO_CLEAN_SHARED: begin
                  second_k = TX_CLEAN_SHARED;
                  if (cur == LINE_DIRTY) begin
                    first_k   = TX_WRITE_CLEAN;
                    table_we  = 1'b1;
                    table_val = LINE_CLEAN;
                  end
                end
                CMO_CLEAN_INVALID: begin
                  second_k  = TX_CLEAN_INVALID;
                  table_we  = 1'b1;
                  table_val = LINE_INVALID;
                  if (cur == LINE_DIRTY) begin
                    first_k = TX_WRITE_BACK;
                  end
                end
                default: begin
                  second_k  = TX_MAKE_INVALID;
                  table_we  = 1'b1;
                  table_val = LINE_INVALID;
                end
              endcase
              if (first_k == TX_NONE) begin
                first_k  = second_k;
                second_k = TX_NONE;
              end
            end
            OP_BARRIER: begin
              first_k = req.sync ? TX_SYNC_BARRIER
                                 : TX_MEM_BARRIER;
            end
            default: begin
              first_k = TX_NONE;
            end
          endcase
          if (first_k != TX_NONE) begin
            txn_d       = make_txn(first_k, req.idx, req.dom);
            txn_valid_d = 1'b1;
            pend_d      = make_txn(second_k, req.idx, req.dom);
            pend_vld_d  = (second_k != TX_NONE);
            fsm_d       = ST_ISSUE;
          end else begin
            done_d = 1'b1;
          end
        end
      end
      ST_ISSUE: begin
        if (txn_ready) begin
          txn_valid_d = 1'b0;
          got_rd_d    = 1'b0;
          got_wr_d    = 1'b0;
          fsm_d       = ST_WAIT;
        end
      end
      ST_WAIT: begin
        got_rd_d = got_rd_q || rd_done;
        got_wr_d = got_wr_q || wr_done;
        // Barriers need both channel answers before moving on
        if (rd_ok && wr_ok) begin
          if (pend_vld_q) begin
            txn_d       = pend_q;
            txn_valid_d = 1'b1;
            pend_vld_d  = 1'b0;
            fsm_d       = ST_ISSUE;
          end else begin
            done_d = 1'b1;
            fsm_d  = ST_IDLE;
          end
        end
      end
      default: begin
        fsm_d = ST_IDLE;
      end
    endcase
    ready_d = (fsm_d == ST_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fsm_q       <= ST_IDLE;
      txn_q       <= TXN_RESET;
      txn_valid_q <= 1'b0;
      pend_q      <= TXN_RESET;
      pend_vld_q  <= 1'b0;
      got_rd_q    <= 1'b0;
      got_wr_q    <= 1'b0;
      done_q      <= 1'b0;
      ready_q     <= 1'b0;
    end else begin
      fsm_q       <= fsm_d;
      txn_q       <= txn_d;
      txn_valid_q <= txn_valid_d;
      pend_q      <= pend_d;
      pend_vld_q  <= pend_vld_d;
      got_rd_q    <= got_rd_d;
      got_wr_q    <= got_wr_d;
      done_q      <= done_d;
      ready_q     <= ready_d;
    end
  end

  // Snoop handling
  assign snp_cur = state_q[snp.idx];

  snoop_decide u_snoop_decide (
    .kind (snp.kind),
    .cur  (snp_cur),
    .nxt  (snp_next),
    .rsp  (snp_dec)
  );

  always_comb begin
    rsp_vld_d = snp_valid;
    rsp_d     = snp_valid ? snp_dec : RSP_RESET;
    dvld_d    = snp_valid && snp_dec.data_xfer;
    didx_d    = snp.idx;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_vld_q <= 1'b0;
      rsp_q     <= RSP_RESET;
      dvld_q    <= 1'b0;
      didx_q    <= '0;
    end else begin
      rsp_vld_q <= rsp_vld_d;
      rsp_q     <= rsp_d;
      dvld_q    <= dvld_d;
      didx_q    <= didx_d;
    end
  end

  // Line state table, snoop update applied last
  generate
    for (genvar g = 0; g < LINES; g++) begin : g_line
      always_comb begin
        state_d[g] = state_q[g];
        if (table_we && table_idx == IDX_W'(g)) begin
          state_d[g] = table_val;
        end
        if (snp_valid && snp.idx == IDX_W'(g)) begin
          state_d[g] = snp_next;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          state_q[g] <= LINE_RESET;
        end else begin
          state_q[g] <= state_d[g];
        end
      end
    end
  endgenerate

  assign req_ready      = ready_q;
  assign op_done        = done_q;
  assign txn_valid      = txn_valid_q;
  assign txn            = txn_q;
  assign snp_rsp_valid  = rsp_vld_q;
  assign snp_rsp        = rsp_q;
  assign snp_data_valid = dvld_q;
  assign snp_data_idx   = didx_q;

endmodule : coherent_cache_transaction_agent
`default_nettype wire

// file: src/agent_pkg.sv
// Behaviour
// - Full-line unique write only for whole lines
// - Snapshot reads, partial unique writes may be partial
// - Dirty eviction uses write-back, copy dropped
// - Cleaning dirty line uses write-clean, copy kept
// - Clean line may be written to lower cache
// - Address-only eviction notice when no update needed
// - Broadcast maintenance also applied to local cache
// - Clean-shared snoop on dirty line supplies data
// - Clean-invalidate snoop on clean line drops it
// - Clean-invalidate snoop on dirty: supply, then drop
// - Make-invalid snoop drops line, no data needed
// - Every snoop gets a response, data optional
// - Four shareability levels, system covers all
// - Domain membership consistent and symmetric
// - System-shareable accesses are never cached
// - Transaction domain selects which masters snooped
// - Memory barrier orders observation across domain
// - Sync barrier completes when earlier traffic observable
package agent_pkg;

  localparam int IDX_W = 4;
  localparam int LINES = 16;

  typedef enum logic [1:0] {
    LINE_INVALID,
    LINE_CLEAN,
    LINE_DIRTY
  } line_state_t;

  localparam line_state_t LINE_RESET = LINE_INVALID;

  // Carried on every transaction so the far side picks snoop targets
  typedef enum logic [1:0] {
    DOM_NON,
    DOM_INNER,
    DOM_OUTER,
    DOM_SYSTEM
  } domain_t;

  typedef enum logic [2:0] {
    OP_READ_ONCE,
    OP_STORE,
    OP_FILL,
    OP_WRITE_LOCAL,
    OP_EVICT,
    OP_CLEAN,
    OP_CMO,
    OP_BARRIER
  } op_t;

  typedef enum logic [1:0] {
    CMO_CLEAN_SHARED,
    CMO_CLEAN_INVALID,
    CMO_MAKE_INVALID
  } cmo_t;

  typedef enum logic [3:0] {
    TX_NONE,
    TX_READ_ONCE,
    TX_WRITE_UNIQUE,
    TX_WRITE_LINE_UNIQUE,
    TX_WRITE_BACK,
    TX_WRITE_CLEAN,
    TX_WRITE_EVICT,
    TX_EVICT,
    TX_CLEAN_SHARED,
    TX_CLEAN_INVALID,
    TX_MAKE_INVALID,
    TX_MEM_BARRIER,
    TX_SYNC_BARRIER
  } txn_kind_t;

  typedef enum logic [2:0] {
    SNP_READ_ONCE,
    SNP_READ_SHARED,
    SNP_READ_UNIQUE,
    SNP_CLEAN_SHARED,
    SNP_CLEAN_INVALID,
    SNP_MAKE_INVALID
  } snp_kind_t;

  typedef struct packed {
    op_t              op;
    cmo_t             cmo;
    logic [IDX_W-1:0] idx;
    domain_t          dom;
    logic             full_line;
    logic             to_lower;
    logic             sync;
  } req_t;

  typedef struct packed {
    txn_kind_t        kind;
    logic [IDX_W-1:0] idx;
    domain_t          dom;
    logic             has_data;
    logic             on_rd;
    logic             on_wr;
  } txn_t;

  typedef struct packed {
    snp_kind_t        kind;
    logic [IDX_W-1:0] idx;
  } snp_t;

  typedef struct packed {
    logic data_xfer;
    logic was_dirty;
    logic keeps;
  } snp_rsp_t;

  localparam txn_t     TXN_RESET = '0;
  localparam snp_rsp_t RSP_RESET = '0;

  function automatic txn_t make_txn(input txn_kind_t k,
                                    input logic [IDX_W-1:0] i,
                                    input domain_t d);
    txn_t t;
    t.kind     = k;
    t.idx      = i;
    t.dom      = d;
    t.has_data = (k == TX_WRITE_UNIQUE) || (k == TX_WRITE_LINE_UNIQUE) ||
                 (k == TX_WRITE_BACK) || (k == TX_WRITE_CLEAN) ||
                 (k == TX_WRITE_EVICT) || (k == TX_READ_ONCE);
    t.on_rd    = (k == TX_READ_ONCE) || (k == TX_CLEAN_SHARED) ||
                 (k == TX_CLEAN_INVALID) || (k == TX_MAKE_INVALID) ||
                 (k == TX_MEM_BARRIER) || (k == TX_SYNC_BARRIER);
    t.on_wr    = !((k == TX_READ_ONCE) || (k == TX_CLEAN_SHARED) ||
                 (k == TX_CLEAN_INVALID) || (k == TX_MAKE_INVALID)) ||
                 (k == TX_MEM_BARRIER) || (k == TX_SYNC_BARRIER);
    return t;
  endfunction : make_txn

endpackage : agent_pkg

// file: src/snoop_decide.sv
`timescale 1ns/100ps
`default_nettype none
module snoop_decide (
  input  wire agent_pkg::snp_kind_t   kind,
  input  wire agent_pkg::line_state_t cur,
  output agent_pkg::line_state_t      nxt,
  output agent_pkg::snp_rsp_t         rsp
);
  import agent_pkg::*;

  logic held;
  logic dirty;

  always_comb begin
    held  = (cur != LINE_INVALID);
    dirty = (cur == LINE_DIRTY);
    nxt   = cur;
    rsp.data_xfer = 1'b0;
    rsp.was_dirty = dirty;
    unique case (kind)
      SNP_READ_ONCE: begin
        rsp.data_xfer = held;
      end
      SNP_READ_SHARED: begin
        rsp.data_xfer = held;
      end
      SNP_READ_UNIQUE: begin
        rsp.data_xfer = held;
        nxt = LINE_INVALID;
      end
      SNP_CLEAN_SHARED: begin
        rsp.data_xfer = dirty;
        if (dirty) begin
          nxt = LINE_CLEAN;
        end
      end
      SNP_CLEAN_INVALID: begin
        rsp.data_xfer = dirty;
        nxt = LINE_INVALID;
      end
      SNP_MAKE_INVALID: begin
        nxt = LINE_INVALID;
      end
      default: begin
        nxt = cur;
      end
    endcase
    rsp.keeps = (nxt != LINE_INVALID);
  end

endmodule : snoop_decide
`default_nettype wire

// file: bench/agent_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module agent_checker (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  req_valid,
  input wire agent_pkg::req_t       req,
  input wire logic                  req_ready,
  input wire logic                  txn_valid,
  input wire agent_pkg::txn_t       txn,
  input wire logic                  snp_valid,
  input wire agent_pkg::snp_t       snp,
  input wire logic                  snp_rsp_valid,
  input wire agent_pkg::snp_rsp_t   snp_rsp,
  input wire logic                  snp_data_valid
);
  import agent_pkg::*;
  req_t cur_q;
  req_t cur_d;
  // Request held by the agent
  always_comb begin
    cur_d = cur_q;
    if (req_valid && req_ready && !snp_valid) cur_d = req;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cur_q <= '0;
    else cur_q <= cur_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_snp(snp_kind_t k);
    snp_valid && snp.kind == k;
  endsequence
  property p_rsp;
    snp_valid |=> snp_rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("snoop unanswered");
  property p_quiet;
    !snp_valid |=> !snp_rsp_valid && !snp_data_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray response");
  property p_clsh;
    s_snp(SNP_CLEAN_SHARED) ##1 snp_rsp.was_dirty |-> snp_data_valid;
  endproperty
  a_clsh: assert property (p_clsh) else $error("dirty not supplied");
  property p_cli_drop;
    s_snp(SNP_CLEAN_INVALID) |=> !snp_rsp.keeps;
  endproperty
  a_cli_drop: assert property (p_cli_drop) else $error("line kept");
  property p_cli_data;
    s_snp(SNP_CLEAN_INVALID) |=> snp_data_valid == snp_rsp.was_dirty;
  endproperty
  a_cli_data: assert property (p_cli_data) else $error("bad data");
  property p_mki;
    s_snp(SNP_MAKE_INVALID) |=> !snp_data_valid && !snp_rsp.keeps;
  endproperty
  a_mki: assert property (p_mki) else $error("make invalid");
  property p_wlu;
    txn_valid && txn.kind == TX_WRITE_LINE_UNIQUE |-> cur_q.full_line;
  endproperty
  a_wlu: assert property (p_wlu) else $error("partial full-line");
  property p_evict;
    txn_valid && txn.kind == TX_EVICT |-> !txn.has_data;
  endproperty
  a_evict: assert property (p_evict) else $error("evict data");
  property p_dom;
    txn_valid |-> txn.dom == cur_q.dom && txn.idx == cur_q.idx;
  endproperty
  a_dom: assert property (p_dom) else $error("domain mismatch");
endmodule : agent_checker
bind coherent_cache_transaction_agent agent_checker agent_checker_inst (
  .clk, .rst, .req_valid, .req, .req_ready, .txn_valid, .txn, .snp_valid,
  .snp, .snp_rsp_valid, .snp_rsp, .snp_data_valid);
`default_nettype wire

// file: bench/ic_model.sv
`timescale 1ns/100ps
`default_nettype none
module ic_model (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            txn_valid,
  input  wire agent_pkg::txn_t txn,
  output logic                 txn_ready,
  output logic                 rd_done,
  output logic                 wr_done
);
  import agent_pkg::*;
  logic rd;
  logic wr;
  // Memory updates never spawn snoops or serialization
  // Done only after ordering and collating
  initial begin
    txn_ready = 0;
    rd_done = 0;
    wr_done = 0;
    forever begin
      @(posedge clk);
      #1;
      if (!rst && txn_valid) begin
        repeat ($urandom_range(3)) @(posedge clk);
        #1;
        rd = txn.on_rd;
        wr = txn.on_wr;
        txn_ready = 1;
        @(posedge clk);
        #1;
        txn_ready = 0;
        repeat (1 + $urandom_range(3)) @(posedge clk);
        #1;
        rd_done = rd;
        wr_done = wr;
        @(posedge clk);
        #1;
        rd_done = 0;
        wr_done = 0;
      end
    end
  end
endmodule : ic_model
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import agent_pkg::*;
  logic             clk;
  logic             rst;
  logic             req_valid;
  req_t             req;
  logic             req_ready;
  logic             op_done;
  logic             txn_valid;
  txn_t             txn;
  logic             txn_ready;
  logic             rd_done;
  logic             wr_done;
  logic             snp_valid;
  snp_t             snp;
  logic             snp_rsp_valid;
  snp_rsp_t         snp_rsp;
  logic             snp_data_valid;
  logic [IDX_W-1:0] snp_data_idx;
  logic [IDX_W-1:0] i;
  domain_t          d;
  int               fail_count;
  int               checks;
  int               cycles;
  txn_kind_t        exp_txn[$];
  logic [6:0]       exp_snp[$];
  logic [6:0]       e;

  coherent_cache_transaction_agent coherent_cache_transaction_agent_inst (
    .clk, .rst, .req_valid, .req, .req_ready, .op_done, .txn_valid, .txn,
    .txn_ready, .rd_done, .wr_done, .snp_valid, .snp, .snp_rsp_valid,
    .snp_rsp, .snp_data_valid, .snp_data_idx);
  ic_model ic_model_inst (
    .clk, .rst, .txn_valid, .txn, .txn_ready, .rd_done, .wr_done);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic check(string what, logic [7:0] x, logic [7:0] s);
    checks++;
    if (x !== s) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, x, s);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic op(op_t o, cmo_t c, domain_t dm, logic fl, logic lo,
                    logic sy);
    int n;
    @(posedge clk);
    #1;
    req_valid = 1;
    req = '{o, c, i, dm, fl, lo, sy};
    n = 0;
    while (!req_ready && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    req_valid = 0;
    req = req_t'($urandom);
    n = 0;
    while (!op_done && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (op_done !== 1'b1) check("op_done", 8'h1, 8'h0);
  endtask : op

  task automatic snoop(snp_kind_t k, logic x, logic dy);
    @(posedge clk);
    #1;
    snp_valid = 1;
    snp = '{k, i};
    exp_snp.push_back({x, x, dy, i});
    @(posedge clk);
    #1;
    snp_valid = 0;
    snp = ~snp;
  endtask : snoop

  task automatic dirty;
    op(OP_FILL, CMO_CLEAN_SHARED, d, 0, 0, 0);
    op(OP_WRITE_LOCAL, CMO_CLEAN_SHARED, d, 0, 0, 0);
  endtask : dirty

  always @(negedge clk) begin
    if (txn_valid && txn_ready) begin
      if (exp_txn.size() == 0) check("txn extra", 8'h0, 8'h1);
      else check("txn", 8'(exp_txn.pop_front()), 8'(txn.kind));
    end
    if (snp_rsp_valid) begin
      e = exp_snp.size() ? exp_snp.pop_front() : 7'h7f;
      check("snp", 8'(e), {1'b0, snp_data_valid, snp_rsp.data_xfer,
            snp_rsp.was_dirty, snp_data_valid ? snp_data_idx : e[3:0]});
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    rst = 1;
    req_valid = 0;
    req = '0;
    snp_valid = 0;
    snp = '0;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(58564));
    repeat (10) @(posedge clk);
    #1;
    rst = 0;
    for (int r = 0; r < 3; r++) begin
      i = IDX_W'($urandom_range(15));
      d = domain_t'($urandom_range(2));
      dirty();
      exp_txn.push_back(TX_WRITE_BACK);
      op(OP_EVICT, CMO_CLEAN_SHARED, d, 0, 0, 0);
      snoop(SNP_READ_SHARED, 0, 0);
      dirty();
      exp_txn.push_back(TX_WRITE_CLEAN);
      op(OP_CLEAN, CMO_CLEAN_SHARED, d, 0, 0, 0);
      snoop(SNP_READ_SHARED, 1, 0);
      $display("test write_back_clean done");
      op(OP_FILL, CMO_CLEAN_SHARED, d, 0, 0, 0);
      exp_txn.push_back(TX_WRITE_EVICT);
      op(OP_EVICT, CMO_CLEAN_SHARED, d, 0, 1, 0);
      op(OP_FILL, CMO_CLEAN_SHARED, d, 0, 0, 0);
      exp_txn.push_back(TX_EVICT);
      op(OP_EVICT, CMO_CLEAN_SHARED, d, 0, 0, 0);
      op(OP_EVICT, CMO_CLEAN_SHARED, d, 0, 0, 0);
      $display("test eviction done");
      exp_txn.push_back(TX_WRITE_LINE_UNIQUE);
      op(OP_STORE, CMO_CLEAN_SHARED, d, 1, 0, 0);
      dirty();
      exp_txn.push_back(TX_WRITE_BACK);
      exp_txn.push_back(TX_WRITE_UNIQUE);
      op(OP_STORE, CMO_CLEAN_SHARED, d, 0, 0, 0);
      snoop(SNP_READ_SHARED, 0, 0);
      $display("test store done");
      for (int c = 0; c < 3; c++) begin
        dirty();
        if (c == 0) exp_txn.push_back(TX_WRITE_CLEAN);
        if (c == 1) exp_txn.push_back(TX_WRITE_BACK);
        exp_txn.push_back(txn_kind_t'(TX_CLEAN_SHARED + c));
        op(OP_CMO, cmo_t'(c), d, 0, 0, 0);
        snoop(SNP_READ_SHARED, c == 0, 0);
      end
      $display("test maintenance done");
      dirty();
      snoop(SNP_CLEAN_SHARED, 1, 1);
      snoop(SNP_CLEAN_INVALID, 0, 0);
      snoop(SNP_READ_SHARED, 0, 0);
      dirty();
      snoop(SNP_CLEAN_INVALID, 1, 1);
      op(OP_FILL, CMO_CLEAN_SHARED, d, 0, 0, 0);
      snoop(SNP_MAKE_INVALID, 0, 0);
      snoop(SNP_READ_ONCE, 0, 0);
      $display("test snoops done");
      op(OP_FILL, CMO_CLEAN_SHARED, DOM_SYSTEM, 0, 0, 0);
      snoop(SNP_READ_SHARED, 0, 0);
      exp_txn.push_back(TX_READ_ONCE);
      op(OP_READ_ONCE, CMO_CLEAN_SHARED, d, 0, 0, 0);
      exp_txn.push_back(TX_MEM_BARRIER);
      op(OP_BARRIER, CMO_CLEAN_SHARED, d, 0, 0, 0);
      exp_txn.push_back(TX_SYNC_BARRIER);
      op(OP_BARRIER, CMO_CLEAN_SHARED, d, 0, 0, 1);
      $display("test system_barrier done");
    end
    repeat (5) @(posedge clk);
    check("pending", 8'h0, 8'(exp_txn.size() + exp_snp.size()));
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
